// *** src/bypass_deglitch.sv ***
// Bypass switch control: instant turn-off, deglitched turn-on
`timescale 1ns/10ps
`default_nettype none
module bypass_deglitch
    import chg_status_pkg::*;
#(
    parameter int CYCLES = DEGLITCH_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic drop_now,
    input wire logic rise_ok,
    output logic switch_on
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    generate
        if (CYCLES < 1) begin : g_bad
            $error("CYCLES must be at least one");
        end
    endgenerate

    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic next_switch_on;

    always_comb begin
        next_cnt = '0;
        next_switch_on = switch_on;
        if (drop_now) begin
            next_switch_on = 1'b0;
        end else if (!switch_on && rise_ok) begin
            if (cnt == LAST) begin
                next_switch_on = 1'b1;
            end else begin
                next_cnt = cnt + CW'(1);
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt <= '0;
            switch_on <= 1'b0;
        end else begin
            cnt <= next_cnt;
            switch_on <= next_switch_on;
        end
    end

    AST_BYPASS_QUALIFIED: assert property (@(posedge core_clk) disable iff (rst)
        $rose(switch_on) |-> $past(rise_ok) && !$past(drop_now) && $past(cnt) == LAST)
        else $error("bypass switch turned on without full deglitch");
endmodule
`default_nettype wire

// *** src/charger_status_upper_bits.sv ***
// Upper charger status flags and the protection actions tied to them
// Function
// - Bit 11 high while battery voltage is below the selected depleted threshold.
// - Depleted threshold per cell times three or four cells from voltage setting.
// - Depletion turns battery switch off; adapter switch on when learning.
// - Bit 12 high when the charge-voltage value is outside valid ranges.
// - Accept 9 V, 12-14.4 V, 16-19.2 V; truncate to lower converter step.
// - Above 19.2 V keep charging and clamp target to 19.2 V.
// - Below 12 V except 9 V, or 14.4-16 V: disable charge, flag, alarm.
// - The 9000 mV code regulates to 9 V for battery wake-up.
// - Bit 13 high while battery voltage exceeds adapter sense voltage.
// - Bypass off at once within 150 mV; on after 8 ms and 100 mV.
// - Bit 14 follows the thermistor-pin battery-detect comparator.
// - Charging stops at once when battery presence is lost.
// - Bit 15 high while adapter-detect input is above its threshold.
// - Charging blocked and 5 V reference off until adapter detected.
// - Internal reset and SMBus enable released at 1.2 V detect and 6.5 V supply.
// - Alert goes active 6 to 10 ms after any status bit changes.
`timescale 1ns/10ps
`default_nettype none
module charger_status_upper_bits
    import chg_status_pkg::*;
#(
    parameter int STEP_LSB_BITS = 4,
    parameter int DEPL_BASE_MV = 2800,
    parameter int DEPL_STEP_MV = 100,
    parameter int DEGLITCH_CNT = DEGLITCH_CYCLES,
    parameter int ALERT_CNT = ALERT_MIN_CYCLES,
    parameter int ALERT_LO = ALERT_MIN_CYCLES,
    parameter int ALERT_HI = ALERT_MAX_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [15:0] charger_mode,
    input wire logic [15:0] charge_voltage_mv,
    input wire sense_t sense,
    input wire comparator_t comparators,
    input wire logic status_read,
    output status_word_t charger_condition_flags,
    output logic battery_switch_drive,
    output logic adapter_switch_drive,
    output logic bypass_switch_on,
    output logic charge_enable,
    output logic [15:0] regulation_target_mv,
    output logic range_alarm,
    output logic five_volt_reference_output,
    output logic smbus_enable,
    output logic alert
);
    localparam int AW = $clog2(ALERT_CNT + 1);
    localparam logic [AW-1:0] ALERT_LAST = AW'(ALERT_CNT - 1);

    generate
        if (STEP_LSB_BITS < 0 || STEP_LSB_BITS > 8) begin : g_bad_step
            $error("STEP_LSB_BITS out of range");
        end
        if (ALERT_CNT < ALERT_LO || ALERT_CNT > ALERT_HI) begin : g_bad_alert
            $error("ALERT_CNT outside the alert window");
        end
        if (DEPL_BASE_MV + 7 * DEPL_STEP_MV > 16000) begin : g_bad_depl
            $error("Depleted threshold too large");
        end
    endgenerate

    status_word_t next_flags;
    logic [2:0] cells;
    logic [2:0] depl_sel;
    logic [17:0] depl_threshold;
    logic [15:0] cv_trunc;
    logic cv_in_low;
    logic cv_in_high;
    logic cv_above;
    logic cv_wake;
    logic cv_ok;
    logic [16:0] bat_ext;
    logic [16:0] adp_ext;
    logic bypass_drop;
    logic bypass_rise;
    logic next_battery_switch_drive;
    logic next_adapter_switch_drive;
    logic next_charge_enable;
    logic [15:0] next_regulation_target_mv;
    logic next_range_alarm;
    logic next_five_volt_reference_output;
    logic next_smbus_enable;
    alert_state_t alert_state;
    alert_state_t next_alert_state;
    logic [AW-1:0] alert_cnt;
    logic [AW-1:0] next_alert_cnt;
    logic next_alert;
    logic status_change;

    // Range classification and step truncation of the programmed charge voltage
    always_comb begin
        cv_trunc = charge_voltage_mv & ~16'((17'h1_0000 >> (16 - STEP_LSB_BITS)) - 17'h0_0001);
        cv_wake = charge_voltage_mv == CV_WAKE_MV;
        cv_in_low = charge_voltage_mv >= CV_3CELL_MIN_MV && charge_voltage_mv <= CV_3CELL_MAX_MV;
        cv_in_high = charge_voltage_mv >= CV_4CELL_MIN_MV && charge_voltage_mv <= CV_4CELL_MAX_MV;
        cv_above = charge_voltage_mv > CV_4CELL_MAX_MV;
        cv_ok = cv_wake || cv_in_low || cv_in_high || cv_above;
        cells = (cv_in_high || cv_above) ? CELLS_HIGH : CELLS_LOW;
        depl_sel = charger_mode[DEPL_SEL_LSB +: DEPL_SEL_W];
        depl_threshold = 18'((DEPL_BASE_MV + int'(depl_sel) * DEPL_STEP_MV) * int'(cells));
        bat_ext = {1'b0, sense.battery_mv};
        adp_ext = {1'b0, sense.adapter_sense_pin_mv};
        bypass_drop = adp_ext < bat_ext + BYPASS_OFF_MARGIN_MV;
        bypass_rise = adp_ext >= bat_ext + BYPASS_OFF_MARGIN_MV + BYPASS_HYST_MV;
    end

    // Live status word and protection outputs
    always_comb begin
        next_flags = '0;
        next_flags.battery_depleted_flag = {2'b00, sense.battery_mv} < depl_threshold;
        next_flags.voltage_range_error_flag = !(cv_wake || cv_in_low || cv_in_high);
        next_flags.adapter_below_battery_flag =
            sense.battery_mv > sense.adapter_sense_pin_mv;
        next_flags.battery_present_flag =
            comparators.thermistor_sense_pin_below_detect;
        next_flags.adapter_detected_flag =
            comparators.adapter_detect_input_above_detect;
        // Power-on release is worked out first so that charge gating sees this cycle's value
        next_smbus_enable = comparators.adapter_detect_input_above_por &&
            comparators.vcc_above_por;
        next_battery_switch_drive = !next_flags.battery_depleted_flag;
        next_adapter_switch_drive = next_flags.adapter_detected_flag &&
            (!charger_mode[LEARN_BIT] || next_flags.battery_depleted_flag);
        next_charge_enable = cv_ok && next_flags.battery_present_flag &&
            next_flags.adapter_detected_flag && next_smbus_enable;
        if (cv_above) begin
            next_regulation_target_mv = CV_4CELL_MAX_MV;
        end else if (cv_wake) begin
            next_regulation_target_mv = CV_WAKE_MV;
        end else begin
            next_regulation_target_mv = cv_trunc;
        end
        next_range_alarm = !cv_ok;
        next_five_volt_reference_output = next_flags.adapter_detected_flag;
    end

    // Alert timing after a status change; a change in the read cycle clears alert and restarts the wait
    always_comb begin
        status_change = next_flags != charger_condition_flags;
        next_alert_state = alert_state;
        next_alert_cnt = '0;
        next_alert = alert;
        case (alert_state)
            ALERT_IDLE: begin
                if (status_change) begin
                    next_alert_state = ALERT_WAIT;
                end
            end
            ALERT_WAIT: begin
                if (alert_cnt == ALERT_LAST) begin
                    next_alert_state = ALERT_ON;
                    next_alert = 1'b1;
                end else begin
                    next_alert_cnt = alert_cnt + AW'(1);
                end
            end
            ALERT_ON: begin
                if (status_read) begin
                    next_alert = 1'b0;
                    next_alert_state = status_change ? ALERT_WAIT : ALERT_IDLE;
                end
            end
            default: begin
                next_alert_state = ALERT_IDLE;
                next_alert = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            charger_condition_flags <= '0;
            battery_switch_drive <= 1'b0;
            adapter_switch_drive <= 1'b0;
            charge_enable <= 1'b0;
            regulation_target_mv <= '0;
            range_alarm <= 1'b0;
            five_volt_reference_output <= 1'b0;
            smbus_enable <= 1'b0;
            alert_state <= ALERT_IDLE;
            alert_cnt <= '0;
            alert <= 1'b0;
        end else begin
            charger_condition_flags <= next_flags;
            battery_switch_drive <= next_battery_switch_drive;
            adapter_switch_drive <= next_adapter_switch_drive;
            charge_enable <= next_charge_enable;
            regulation_target_mv <= next_regulation_target_mv;
            range_alarm <= next_range_alarm;
            five_volt_reference_output <= next_five_volt_reference_output;
            smbus_enable <= next_smbus_enable;
            alert_state <= next_alert_state;
            alert_cnt <= next_alert_cnt;
            alert <= next_alert;
        end
    end

    bypass_deglitch #(
        .CYCLES(DEGLITCH_CNT)
    ) u_bypass (
        .core_clk(core_clk),
        .rst(rst),
        .drop_now(bypass_drop),
        .rise_ok(bypass_rise),
        .switch_on(bypass_switch_on)
    );

    AST_DEPLETED_DRIVES: assert property (@(posedge core_clk) disable iff (rst)
        charger_condition_flags.battery_depleted_flag |-> !battery_switch_drive)
        else $error("battery switch on while depleted");
    AST_DEPLETED_FLAG: assert property (@(posedge core_clk) disable iff (rst)
        {2'b00, sense.battery_mv} < depl_threshold |=> charger_condition_flags.battery_depleted_flag)
        else $error("depleted flag missing");
    AST_RANGE_FLAG: assert property (@(posedge core_clk) disable iff (rst)
        (charge_voltage_mv > CV_3CELL_MAX_MV && charge_voltage_mv < CV_4CELL_MIN_MV)
        |=> charger_condition_flags.voltage_range_error_flag && !charge_enable && range_alarm)
        else $error("gap voltage not refused");
    AST_CLAMP: assert property (@(posedge core_clk) disable iff (rst)
        cv_above |=> regulation_target_mv == CV_4CELL_MAX_MV && !range_alarm)
        else $error("high voltage not clamped");
    AST_WAKE: assert property (@(posedge core_clk) disable iff (rst)
        cv_wake |=> regulation_target_mv == CV_WAKE_MV
        && !charger_condition_flags.voltage_range_error_flag)
        else $error("wake voltage not regulated");
    AST_ADAPTER_BELOW: assert property (@(posedge core_clk) disable iff (rst)
        charger_condition_flags.adapter_below_battery_flag
        == $past(sense.battery_mv > sense.adapter_sense_pin_mv))
        else $error("adapter below battery flag wrong");
    AST_BYPASS_DROP: assert property (@(posedge core_clk) disable iff (rst)
        bypass_drop |=> !bypass_switch_on)
        else $error("bypass switch not dropped");
    AST_BATT_LOST: assert property (@(posedge core_clk) disable iff (rst)
        !comparators.thermistor_sense_pin_below_detect |=> !charge_enable
        && !charger_condition_flags.battery_present_flag)
        else $error("charge kept without battery");
    AST_ADAPTER_GATE: assert property (@(posedge core_clk) disable iff (rst)
        !charger_condition_flags.adapter_detected_flag |-> !charge_enable
        && !five_volt_reference_output)
        else $error("charge or reference on without adapter");
    AST_POR: assert property (@(posedge core_clk) disable iff (rst)
        smbus_enable == $past(comparators.adapter_detect_input_above_por
        && comparators.vcc_above_por))
        else $error("smbus enable wrong");
    AST_ALERT_TIME: assert property (@(posedge core_clk) disable iff (rst)
        $rose(alert) |-> $past(alert_state) == ALERT_WAIT && $past(alert_cnt) == ALERT_LAST)
        else $error("alert rose early");
endmodule
`default_nettype wire

// *** src/chg_status_pkg.sv ***
// Constants, carrier types and state codes for the charger upper status block
package chg_status_pkg;
    localparam int MV_W = 16;
    localparam logic [15:0] CV_WAKE_MV = 16'h2328;
    localparam logic [15:0] CV_3CELL_MIN_MV = 16'h2EE0;
    localparam logic [15:0] CV_3CELL_MAX_MV = 16'h3840;
    localparam logic [15:0] CV_4CELL_MIN_MV = 16'h3E80;
    localparam logic [15:0] CV_4CELL_MAX_MV = 16'h4B00;
    localparam logic [16:0] BYPASS_OFF_MARGIN_MV = 17'h0_0096;
    localparam logic [16:0] BYPASS_HYST_MV = 17'h0_0064;
    localparam int DEPL_SEL_LSB = 9;
    localparam int DEPL_SEL_W = 3;
    localparam int LEARN_BIT = 4;
    localparam logic [2:0] CELLS_LOW = 3'h3;
    localparam logic [2:0] CELLS_HIGH = 3'h4;
    localparam int CLK_PERIOD_NS = 10;
    localparam int NS_PER_MS = 1000000;
    localparam int DEGLITCH_MS = 8;
    localparam int ALERT_MIN_MS = 6;
    localparam int ALERT_MAX_MS = 10;
    localparam int DEGLITCH_CYCLES = (DEGLITCH_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ALERT_MIN_CYCLES = (ALERT_MIN_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ALERT_MAX_CYCLES = (ALERT_MAX_MS * NS_PER_MS) / CLK_PERIOD_NS;

    typedef struct packed {
        logic adapter_detected_flag;
        logic battery_present_flag;
        logic adapter_below_battery_flag;
        logic voltage_range_error_flag;
        logic battery_depleted_flag;
        logic [10:0] lower_bits;
    } status_word_t;

    typedef struct packed {
        logic [15:0] battery_mv;
        logic [15:0] adapter_sense_pin_mv;
    } sense_t;

    typedef struct packed {
        logic thermistor_sense_pin_below_detect;
        logic adapter_detect_input_above_detect;
        logic adapter_detect_input_above_por;
        logic vcc_above_por;
    } comparator_t;

    typedef enum logic [1:0] {
        ALERT_IDLE = 2'b00,
        ALERT_WAIT = 2'b01,
        ALERT_ON = 2'b10
    } alert_state_t;
endpackage

// *** testbench/host_status_reader.sv ***
// Host model: reads the status word a few cycles after alert rises
`timescale 1ns/10ps
`default_nettype none
module host_status_reader
    import chg_status_pkg::*;
#(
    parameter int READ_DELAY = 3
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic alert,
    input wire status_word_t flags,
    output logic status_read,
    output status_word_t last_read
);
    int wait_cnt;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wait_cnt <= 0;
            status_read <= 1'b0;
            last_read <= '0;
        end else begin
            status_read <= 1'b0;
            if (alert === 1'b1 && !status_read) begin
                wait_cnt <= wait_cnt + 1;
                if (wait_cnt == READ_DELAY) begin
                    status_read <= 1'b1;
                    last_read <= flags;
                    wait_cnt <= 0;
                end
            end else begin
                wait_cnt <= 0;
            end
        end
    end
endmodule
`default_nettype wire

// *** testbench/test_charger_status_upper_bits.sv ***
// Self-checking bench for the upper charger status flags
`timescale 1ns/10ps
`default_nettype none
module test_charger_status_upper_bits;
    import chg_status_pkg::*;
    localparam int DG = 8;
    localparam int AL_HI = 10;
    localparam int D_BASE = 2800;
    localparam int D_STEP = 100;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] mode = 16'h0000;
    logic [15:0] cv = 16'h0000;
    sense_t sn = '0;
    comparator_t cmp = '0;
    logic status_read, bat_drv, ac_drv, byp, chg_en, alarm, vref, smb, alert;
    logic [15:0] target;
    status_word_t flags, host_seen;
    logic [15:0] corner [12] = '{16'h2328, 16'h2EDF, 16'h2EE0, 16'h2EE7, 16'h3840, 16'h3841,
        16'h3E7F, 16'h3E80, 16'h4B00, 16'h4B01, 16'hFFFF, 16'h0000};
    int miscompares = 0;
    int n_compared = 0;
    int n;
    always #5 core_clk = ~core_clk;
    charger_status_upper_bits #(.STEP_LSB_BITS(4), .DEPL_BASE_MV(D_BASE),
        .DEPL_STEP_MV(D_STEP), .DEGLITCH_CNT(DG), .ALERT_CNT(5), .ALERT_LO(5),
        .ALERT_HI(AL_HI)) charger_status_upper_bits_i (
        .core_clk(core_clk), .rst(rst), .charger_mode(mode), .charge_voltage_mv(cv),
        .sense(sn), .comparators(cmp), .status_read(status_read),
        .charger_condition_flags(flags), .battery_switch_drive(bat_drv),
        .adapter_switch_drive(ac_drv), .bypass_switch_on(byp), .charge_enable(chg_en),
        .regulation_target_mv(target), .range_alarm(alarm),
        .five_volt_reference_output(vref), .smbus_enable(smb), .alert(alert));
    host_status_reader host_status_reader_i (.core_clk(core_clk), .rst(rst),
        .alert(alert), .flags(flags), .status_read(status_read), .last_read(host_seen));

    task automatic cmp_bit(input string what, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic cmp_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic give_up;
        miscompares++;
        conclude();
    endtask
    task automatic tick(input int k);
        repeat (k) @(negedge core_clk);
    endtask

    function automatic logic range_bad(input logic [15:0] v);
        return !(v == CV_WAKE_MV || (v >= CV_3CELL_MIN_MV && v <= CV_3CELL_MAX_MV)
            || (v >= CV_4CELL_MIN_MV && v <= CV_4CELL_MAX_MV));
    endfunction
    function automatic logic [15:0] cv_target(input logic [15:0] v);
        if (v == CV_WAKE_MV) return v;
        if (v > CV_4CELL_MAX_MV) return CV_4CELL_MAX_MV;
        return v & 16'hFFF0;
    endfunction
    function automatic logic [15:0] depl_mv(input logic [15:0] v, input logic [2:0] sel);
        return 16'((D_BASE + int'(sel) * D_STEP) * ((v >= CV_4CELL_MIN_MV) ? 4 : 3));
    endfunction

    // Compares outputs other than bypass switch and alert (target only when accepted) against values derived from the inputs of the last cycle
    task automatic check_all;
        logic dep, ok, ad, bp, pw, bab;
        dep = sn.battery_mv < depl_mv(cv, mode[11:9]);
        ok = !range_bad(cv) || cv > CV_4CELL_MAX_MV;
        ad = cmp.adapter_detect_input_above_detect;
        bp = cmp.thermistor_sense_pin_below_detect;
        pw = cmp.adapter_detect_input_above_por && cmp.vcc_above_por;
        bab = sn.battery_mv > sn.adapter_sense_pin_mv;
        cmp_bit("depleted", dep, flags.battery_depleted_flag);
        cmp_bit("bat drive", !dep, bat_drv);
        cmp_bit("ac drive", ad && (!mode[LEARN_BIT] || dep), ac_drv);
        cmp_bit("range flag", range_bad(cv), flags.voltage_range_error_flag);
        cmp_bit("alarm", !ok, alarm);
        cmp_bit("charge", ok && bp && ad && pw, chg_en);
        if (ok) cmp_word("target", cv_target(cv), target);
        cmp_bit("bat above ac", bab, flags.adapter_below_battery_flag);
        cmp_bit("present", bp, flags.battery_present_flag);
        cmp_bit("adapter", ad, flags.adapter_detected_flag);
        cmp_bit("vref", ad, vref);
        cmp_bit("smbus", pw, smb);
        cmp_word("low bits", 16'h0000, {5'h00, flags.lower_bits});
    endtask
    task automatic apply;
        tick(1);
        check_all();
    endtask

    initial begin
        void'($urandom(32'h2770));
        tick(3);
        cmp_word("reset flags", 16'h0000, flags);
        tick(3);
        rst = 1'b0;
        for (int i = 0; i < 80; i++) begin
            mode = 16'($urandom);
            cv = (i < 12) ? corner[i] : 16'($urandom_range(20000, 8000));
            sn.battery_mv = 16'($urandom_range(17000, 7000));
            sn.adapter_sense_pin_mv = 16'($urandom_range(20000, 7000));
            cmp = (i % 3 == 0) ? 4'hF : 4'($urandom);
            apply();
        end
        // Battery one below and exactly at each depleted threshold, both cell counts
        for (int s = 0; s < 16; s++) begin
            mode = {4'h0, 3'(s / 2), 9'($urandom)};
            cv = s[0] ? CV_4CELL_MIN_MV : CV_3CELL_MAX_MV;
            for (int k = 0; k < 2; k++) begin
                sn.battery_mv = depl_mv(cv, mode[11:9]) - 16'(1 - k);
                apply();
            end
        end
        cmp = 4'hF;
        sn.battery_mv = 16'h2EE0;
        sn.adapter_sense_pin_mv = 16'h2F00;
        apply();
        cmp_bit("bypass drop", 1'b0, byp);
        sn.adapter_sense_pin_mv = 16'h2FA8;
        tick(DG + 4);
        cmp_bit("bypass hyst", 1'b0, byp);
        sn.adapter_sense_pin_mv = 16'h3000;
        n = 0;
        while (byp !== 1'b1) begin
            tick(1);
            n++;
            if (n > 40) give_up();
        end
        cmp_bit("bypass delay", 1'b1, n >= DG && n <= DG + 2);
        tick(40);
        cmp_bit("alert idle", 1'b0, alert);
        cmp.thermistor_sense_pin_below_detect = 1'b0;
        n = 0;
        while (alert !== 1'b1) begin
            tick(1);
            n++;
            if (n > 40) give_up();
        end
        cmp_bit("alert delay", 1'b1, n >= 5 && n <= AL_HI + 1);
        n = 0;
        while (alert !== 1'b0) begin
            tick(1);
            n++;
            if (n > 40) give_up();
        end
        cmp_bit("host read", 1'b0, host_seen.battery_present_flag);
        check_all();
        conclude();
    end
endmodule
`default_nettype wire
